// ===== inc/scsc_pkg.sv
package scsc_pkg;

    // ==========================================================
    // clock and tick generation
    // ==========================================================
    localparam longint unsigned REF_HZ    = 64'd200000000;
    localparam int              NCO_W     = 24;
    localparam longint unsigned FAST8_HZ  = 64'd8000000;
    localparam longint unsigned FAST12_HZ = 64'd12000000;
    localparam longint unsigned FAST16_HZ = 64'd16000000;
    localparam longint unsigned SLOW_RC_HZ = 64'd32000;
    localparam logic [NCO_W-1:0] FAST8_INC  = NCO_W'((FAST8_HZ << NCO_W) / REF_HZ);
    localparam logic [NCO_W-1:0] FAST12_INC = NCO_W'((FAST12_HZ << NCO_W) / REF_HZ);
    localparam logic [NCO_W-1:0] FAST16_INC = NCO_W'((FAST16_HZ << NCO_W) / REF_HZ);
    localparam logic [NCO_W-1:0] SLOW_INC   = NCO_W'((SLOW_RC_HZ << NCO_W) / REF_HZ);

    // ==========================================================
    // start-up counts, in source ticks
    // ==========================================================
    localparam logic [7:0] XTAL_READY_TICKS  = 8'h80;
    localparam logic [7:0] SLOWRC_READY_TICKS = 8'h01;
    localparam logic [4:0] FAST_READY_TICKS  = 5'h10;

    // ==========================================================
    // register map (byte addresses)
    // ==========================================================
    localparam logic [11:0] SYS_MODE_OFS = 12'h000;
    localparam logic [11:0] CLK_CTRL_OFS = 12'h004;

    localparam int MODE_SRC_LSB   = 5;
    localparam int MODE_SLOW_RDY  = 3;
    localparam int MODE_FAST_RDY  = 2;
    localparam int MODE_IDLE_EN   = 1;
    localparam int MODE_SPEED     = 0;
    localparam int CTRL_SYS_KEEP  = 7;
    localparam int CTRL_FREQ_LSB  = 4;
    localparam int CTRL_XTAL_LP   = 3;

    localparam logic [2:0] SRC_SEL_RST   = 3'h0;
    localparam logic       IDLE_EN_RST   = 1'b1;
    localparam logic       SPEED_RST     = 1'b1;
    localparam logic       SYS_KEEP_RST  = 1'b0;
    localparam logic [1:0] FREQ_SEL_RST  = 2'h0;
    localparam logic       XTAL_LP_RST   = 1'b0;

    // ==========================================================
    // encodings
    // ==========================================================
    typedef enum logic [1:0] {
        SCSC_F8MHZ  = 2'h0,
        SCSC_F12MHZ = 2'h1,
        SCSC_F16MHZ = 2'h2
    } scsc_freq_t;

    // active source: 0 = fast/1, k = fast/2^k (1..6), 7 = low speed
    localparam logic [2:0] SRC_FAST1 = 3'h0;
    localparam logic [2:0] SRC_SLOW  = 3'h7;

endpackage

// ===== src/scsc_nco.sv
`timescale 1ns/1ps
module scsc_nco
#(
    parameter int W = 24
)
(
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    // control
    input  wire logic         run,
    input  wire logic [W-1:0] incr,
    // output
    output logic              tick
);

    logic [W-1:0] acc_ff;
    logic [W:0]   sum;

    assign sum = {1'b0, acc_ff} + {1'b0, incr};

    // ==========================================================
    // phase accumulator, one pulse per carry
    // ==========================================================
    // stopped oscillator keeps phase so restart needs no reset
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_ff <= '0;
            tick   <= 1'b0;
        end
        else
        begin
            if (run)
            begin
                acc_ff <= sum[W-1:0];
            end
            tick <= run & sum[W];
        end
    end

endmodule

// ===== src/scsc_clk_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - fast RC runs at 8, 12 or 16 MHz per two-bit frequency select
// - speed bit and source select pick fast or slow clock, changeable live
// - low-speed source is slow RC or watch crystal, fixed by option
// - every setting yields one fast and one slow source, never none
// - option decides crystal pins serve the crystal or general I/O
// - crystal low-power bit: zero quick-start, one low-power
// - sleep or idle stops the processor clock
// - low-speed oscillators also clock the watchdog and time base
// - low-speed clock runs independent of the system clock but stops in sleep until slow ready returns
// - crystal cannot clock the system or low-speed clock until its start-up delay has passed
// - select 000/001 low speed, 010..111 fast divided by 64 to 2
// - power-on clears crystal low-power bit, quick-start mode
// - switching to low speed stops the fast oscillator
// - slow ready rises 128 ticks after wake for crystal, 1 for RC
module scsc_clk_ctrl
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // processor and option straps
    input  wire logic        cpu_halt,
    input  wire logic        cfg_slow_xtal,
    input  wire logic        cfg_xtal_pins,
    // crystal pins
    input  wire logic        xt1_in,
    input  wire logic        xt2_in,
    output logic             xt1_out,
    output logic             xt1_oe,
    output logic             xt2_out,
    output logic             xt2_oe,
    // pin-shared general I/O
    input  wire logic [1:0]  gpio_out,
    input  wire logic [1:0]  gpio_oe,
    output logic      [1:0]  gpio_in,
    // clock enables and oscillator controls
    output logic             cpu_clk_en,
    output logic             sys_clk_en,
    output logic             low_speed_clk_en,
    output logic             wdt_clk_en,
    output logic             tbase_clk_en,
    output logic             fast_osc_on,
    output logic             crystal_low_power
);

    // ==========================================================
    // registers and straps
    // ==========================================================
    logic [2:0] sysclk_source_sel_ff;
    logic       speed_select_bit_ff;
    logic       idle_en_ff;
    logic       sys_keep_ff;
    logic [1:0] fast_rc_freq_sel_ff;
    logic       crystal_low_power_bit_ff;
    logic       strap_done_ff;
    logic       slow_xtal_ff;
    logic       xtal_pins_ff;
    logic       slow_rdy_ff;
    logic       fast_rdy_ff;
    logic [7:0] slow_cnt_ff;
    logic [4:0] fast_cnt_ff;
    logic [5:0] div_cnt_ff;
    logic [2:0] cur_src_ff;
    logic [1:0] s1_ff, s2_ff, s3_ff;
    logic       xt_lvl_ff;
    logic       xt_edge_ff;

    logic       wr_en, rd_en, hit_mode, hit_ctrl;
    logic [scsc_pkg::NCO_W-1:0] fast_inc;
    logic       fast_tick, rc_tick, slow_raw, slow_tick;
    logic       sleep, stop_sys, fast_en;
    logic [2:0] want_src;
    logic       cur_tick, want_rdy, cur_dead;
    logic [7:0] slow_target;

    localparam int NCO_W_L = scsc_pkg::NCO_W;

    assign wr_en    = psel & penable & pready & pwrite;
    assign rd_en    = psel & penable & ~pready & ~pwrite;
    assign hit_mode = (paddr == scsc_pkg::SYS_MODE_OFS);
    assign hit_ctrl = (paddr == scsc_pkg::CLK_CTRL_OFS);

    // one wait state: ready rises on the second access cycle
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~(hit_mode | hit_ctrl);
            if (rd_en)
            begin
                prdata <= 32'h0000_0000;
                if (hit_mode)
                begin
                    prdata[7:0] <= {sysclk_source_sel_ff, 1'b0, slow_rdy_ff, fast_rdy_ff,
                                    idle_en_ff, speed_select_bit_ff};
                end
                else if (hit_ctrl)
                begin
                    prdata[7:0] <= {sys_keep_ff, 1'b0, fast_rc_freq_sel_ff,
                                    crystal_low_power_bit_ff, 3'h0};
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sysclk_source_sel_ff     <= scsc_pkg::SRC_SEL_RST;
            speed_select_bit_ff      <= scsc_pkg::SPEED_RST;
            idle_en_ff               <= scsc_pkg::IDLE_EN_RST;
            sys_keep_ff              <= scsc_pkg::SYS_KEEP_RST;
            fast_rc_freq_sel_ff      <= scsc_pkg::FREQ_SEL_RST;
            crystal_low_power_bit_ff <= scsc_pkg::XTAL_LP_RST;
        end
        else if (wr_en && hit_mode)
        begin
            sysclk_source_sel_ff <= pwdata[scsc_pkg::MODE_SRC_LSB +: 3];
            idle_en_ff           <= pwdata[scsc_pkg::MODE_IDLE_EN];
            speed_select_bit_ff  <= pwdata[scsc_pkg::MODE_SPEED];
        end
        else if (wr_en && hit_ctrl)
        begin
            sys_keep_ff              <= pwdata[scsc_pkg::CTRL_SYS_KEEP];
            fast_rc_freq_sel_ff      <= pwdata[scsc_pkg::CTRL_FREQ_LSB +: 2];
            crystal_low_power_bit_ff <= pwdata[scsc_pkg::CTRL_XTAL_LP];
        end
    end

    // options are caught once, the first edge after reset release
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            strap_done_ff <= 1'b0;
            slow_xtal_ff  <= 1'b0;
            xtal_pins_ff  <= 1'b0;
        end
        else if (!strap_done_ff)
        begin
            strap_done_ff <= 1'b1;
            slow_xtal_ff  <= cfg_slow_xtal;
            xtal_pins_ff  <= cfg_xtal_pins;
        end
    end

    // ==========================================================
    // crystal pins and synchroniser
    // ==========================================================
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_ff      <= 2'h0;
            s2_ff      <= 2'h0;
            s3_ff      <= 2'h0;
            xt_lvl_ff  <= 1'b0;
            xt_edge_ff <= 1'b0;
            gpio_in    <= 2'h0;
        end
        else
        begin
            s1_ff      <= {xt2_in, xt1_in};
            s2_ff      <= s1_ff;
            s3_ff      <= s2_ff;
            xt_edge_ff <= 1'b0;
            if (s2_ff[0] == s3_ff[0])
            begin
                xt_lvl_ff  <= s3_ff[0];
                xt_edge_ff <= s3_ff[0] & ~xt_lvl_ff;
            end
            gpio_in <= s3_ff;
        end
    end

    // amplifier across the crystal, or plain I/O when the option frees the pins
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            xt1_out <= 1'b0;
            xt1_oe  <= 1'b0;
            xt2_out <= 1'b0;
            xt2_oe  <= 1'b0;
        end
        else if (xtal_pins_ff && strap_done_ff)
        begin
            xt1_out <= 1'b0;
            xt1_oe  <= 1'b0;
            xt2_out <= ~xt_lvl_ff;
            xt2_oe  <= 1'b1;
        end
        else
        begin
            xt1_out <= gpio_out[0];
            xt1_oe  <= gpio_oe[0];
            xt2_out <= gpio_out[1];
            xt2_oe  <= gpio_oe[1];
        end
    end

    // ==========================================================
    // oscillators
    // ==========================================================
    always_comb
    begin
        case (scsc_pkg::scsc_freq_t'(fast_rc_freq_sel_ff))
            scsc_pkg::SCSC_F12MHZ: fast_inc = scsc_pkg::FAST12_INC;
            scsc_pkg::SCSC_F16MHZ: fast_inc = scsc_pkg::FAST16_INC;
            default:               fast_inc = scsc_pkg::FAST8_INC;
        endcase
    end

    scsc_nco #(.W(NCO_W_L)) u_fast_rc_osc
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .run     (fast_osc_on),
        .incr    (fast_inc),
        .tick    (fast_tick)
    );

    scsc_nco #(.W(NCO_W_L)) u_slow_rc_osc
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .run     (strap_done_ff & ~slow_xtal_ff),
        .incr    (scsc_pkg::SLOW_INC),
        .tick    (rc_tick)
    );

    assign slow_raw    = slow_xtal_ff ? xt_edge_ff : rc_tick;
    assign slow_tick   = slow_raw & slow_rdy_ff;
    assign slow_target = slow_xtal_ff ? scsc_pkg::XTAL_READY_TICKS
                                      : scsc_pkg::SLOWRC_READY_TICKS;
    assign sleep       = cpu_halt & ~idle_en_ff;
    assign stop_sys    = cpu_halt & ~(idle_en_ff & sys_keep_ff);

    // ready after power-up and after each wake, low while asleep
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            slow_rdy_ff <= 1'b0;
            slow_cnt_ff <= 8'h00;
        end
        else if (sleep)
        begin
            slow_rdy_ff <= 1'b0;
            slow_cnt_ff <= 8'h00;
        end
        else if (!slow_rdy_ff && slow_raw)
        begin
            slow_cnt_ff <= slow_cnt_ff + 8'h01;
            slow_rdy_ff <= (slow_cnt_ff + 8'h01) >= slow_target;
        end
    end

    // ==========================================================
    // source choice and glitch-free switch
    // ==========================================================
    always_comb
    begin
        if (speed_select_bit_ff)
        begin
            want_src = scsc_pkg::SRC_FAST1;
        end
        else if (sysclk_source_sel_ff[2:1] == 2'h0)
        begin
            want_src = scsc_pkg::SRC_SLOW;
        end
        else
        begin
            want_src = 3'(4'h8 - {1'b0, sysclk_source_sel_ff});
        end
    end

    function automatic logic src_tick(input logic [2:0] src, input logic [5:0] cnt,
                                      input logic ft, input logic st);
        logic [5:0] mask;
        mask = 6'((7'h01 << src) - 7'h01);
        if (src == scsc_pkg::SRC_SLOW)
        begin
            src_tick = st;
        end
        else
        begin
            src_tick = ft & ((cnt & mask) == mask);
        end
    endfunction

    assign cur_tick = src_tick(cur_src_ff, div_cnt_ff, fast_tick, slow_tick);
    assign want_rdy = (want_src == scsc_pkg::SRC_SLOW) ? slow_rdy_ff : fast_rdy_ff;
    assign cur_dead = (cur_src_ff != scsc_pkg::SRC_SLOW) & ~fast_osc_on;
    // fast stays on until the switch to low speed has landed
    assign fast_en  = ~stop_sys & ((want_src != scsc_pkg::SRC_SLOW) |
                                   (cur_src_ff != scsc_pkg::SRC_SLOW));

    // switch only on the old source's pulse, or at once when the old fast source is stopped: no runt period either side
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cur_src_ff <= scsc_pkg::SRC_FAST1;
        end
        else if ((want_src != cur_src_ff) && want_rdy && (cur_tick || cur_dead))
        begin
            cur_src_ff <= want_src;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fast_osc_on <= 1'b0;
            fast_rdy_ff <= 1'b0;
            fast_cnt_ff <= 5'h00;
            div_cnt_ff  <= 6'h00;
        end
        else
        begin
            fast_osc_on <= fast_en;
            if (!fast_osc_on)
            begin
                fast_rdy_ff <= 1'b0;
                fast_cnt_ff <= 5'h00;
            end
            else if (fast_tick && !fast_rdy_ff)
            begin
                fast_cnt_ff <= fast_cnt_ff + 5'h01;
                fast_rdy_ff <= (fast_cnt_ff + 5'h01) == scsc_pkg::FAST_READY_TICKS;
            end
            if (fast_tick)
            begin
                div_cnt_ff <= div_cnt_ff + 6'h01;
            end
        end
    end

    // ==========================================================
    // clock enables
    // ==========================================================
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cpu_clk_en        <= 1'b0;
            sys_clk_en        <= 1'b0;
            low_speed_clk_en  <= 1'b0;
            wdt_clk_en        <= 1'b0;
            tbase_clk_en      <= 1'b0;
            crystal_low_power <= 1'b0;
        end
        else
        begin
            cpu_clk_en        <= cur_tick & ~cpu_halt;
            sys_clk_en        <= cur_tick & ~stop_sys;
            low_speed_clk_en  <= slow_tick;
            wdt_clk_en        <= slow_raw;
            tbase_clk_en      <= slow_raw;
            crystal_low_power <= crystal_low_power_bit_ff;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    a_fast_stops: assert property (@(posedge ref_clk) disable iff (!resetn)
        (cur_src_ff == scsc_pkg::SRC_SLOW && want_src == scsc_pkg::SRC_SLOW)
        |=> !fast_osc_on)
        else $error("fast oscillator still on in low speed");
    a_cpu_halted: assert property (@(posedge ref_clk) disable iff (!resetn)
        cpu_halt |=> !cpu_clk_en)
        else $error("processor clock pulsed while halted");
    a_pins_crystal: assert property (@(posedge ref_clk) disable iff (!resetn)
        (strap_done_ff && xtal_pins_ff) |=> (xt2_oe && !xt1_oe))
        else $error("crystal pins not given to oscillator");
    a_lp_at_por: assert property (@(posedge ref_clk) disable iff (!resetn)
        !strap_done_ff |-> !crystal_low_power_bit_ff && !crystal_low_power)
        else $error("low-power bit set after power-on");
    a_xtal_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
        ($rose(slow_rdy_ff) && slow_xtal_ff) |-> $past(slow_cnt_ff) == 8'h7F)
        else $error("crystal ready before 128 ticks");
    a_sleep_rdy: assert property (@(posedge ref_clk) disable iff (!resetn)
        sleep |=> !slow_rdy_ff)
        else $error("slow ready high in sleep");
    a_div64_sel: assert property (@(posedge ref_clk) disable iff (!resetn)
        (cur_src_ff == 3'h6 && cur_tick) |-> div_cnt_ff == 6'h3F)
        else $error("divide by 64 pulse off phase");
    a_tick_source: assert property (@(posedge ref_clk) disable iff (!resetn)
        cur_tick |-> (fast_tick || slow_tick))
        else $error("system pulse without source pulse");
    a_div_runs: assert property (@(posedge ref_clk) disable iff (!resetn)
        fast_tick |=> div_cnt_ff == 6'($past(div_cnt_ff) + 6'h01))
        else $error("fast divider missed a tick");
    a_switch_edge: assert property (@(posedge ref_clk) disable iff (!resetn)
        (cur_src_ff != $past(cur_src_ff)) |-> $past(cur_tick || cur_dead))
        else $error("source switched between pulses");

endmodule

// ===== tb/scsc_xtal_model.sv
`timescale 1ns/1ps
// ==========================================================
// watch crystal stand-in, far faster than the real part so the
// start-up count fits a short run
// ==========================================================
module scsc_xtal_model
#(
    parameter int HALF = 8
)
(
    // clock
    input  wire logic ref_clk,
    // crystal connected and powered by the pin option
    input  wire logic run,
    // oscillation seen on the first crystal pin
    output logic      xt1
);
    int cnt = 0;

    initial xt1 = 1'b0;

    // stands still while not connected; no free-running edges
    always @(posedge ref_clk)
    begin
        if (run)
        begin
            if (cnt == HALF - 1)
            begin
                cnt <= 0;
                xt1 <= ~xt1;
            end
            else
                cnt <= cnt + 1;
        end
    end
endmodule

// ===== tb/system_clock_source_control_tb.sv
`timescale 1ns/1ps
module system_clock_source_control_tb;
    localparam logic [11:0] SM = scsc_pkg::SYS_MODE_OFS;
    localparam logic [11:0] CC = scsc_pkg::CLK_CTRL_OFS;
    localparam int          XH = 8;
    logic        ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, d;
    logic        pready, pslverr, e, cpu_halt = 0, cfg_slow_xtal = 0, cfg_xtal_pins = 0;
    logic        xt1_in, xt2_in, xt1_out, xt1_oe, xt2_out, xt2_oe, xw, pin1 = 0, pin2 = 0;
    logic [1:0]  gpio_out = 0, gpio_oe = 0, gpio_in;
    logic        cpu_clk_en, sys_clk_en, low_speed_clk_en, wdt_clk_en, tbase_clk_en;
    logic        fast_osc_on, crystal_low_power;
    int          errors = 0, checks = 0, nc = 0, ns = 0, nw = 0, nt = 0, c, s, w, t;
    int          nl = 0, l;
    int          fr[4] = '{8, 12, 16, 8};

    always #2.5 ref_clk = ~ref_clk;
    assign xt1_in = cfg_xtal_pins ? xw : (xt1_oe ? xt1_out : pin1);
    assign xt2_in = xt2_oe ? xt2_out : pin2;

    scsc_xtal_model #(.HALF(XH)) u_scsc_xtal_model (.ref_clk, .run(cfg_xtal_pins), .xt1(xw));
    scsc_clk_ctrl u_scsc_clk_ctrl (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cpu_halt, .cfg_slow_xtal, .cfg_xtal_pins,
        .xt1_in, .xt2_in, .xt1_out, .xt1_oe, .xt2_out, .xt2_oe, .gpio_out, .gpio_oe,
        .gpio_in, .cpu_clk_en, .sys_clk_en, .low_speed_clk_en, .wdt_clk_en, .tbase_clk_en,
        .fast_osc_on, .crystal_low_power);

    // counted on the falling edge, where the enables have settled
    always @(negedge ref_clk)
    begin
        nc += (cpu_clk_en === 1'b1);
        ns += (sys_clk_en === 1'b1);
        nw += (wdt_clk_en === 1'b1);
        nt += (tbase_clk_en === 1'b1);
        nl += (low_speed_clk_en === 1'b1);
    end

    task automatic close_out();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic near(input int got, input int exp);
        check(32'(got >= exp - 1 && got <= exp + 1), 32'h1);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        check(32'(n < 50), 32'h1);
        if (n >= 50)
            close_out();
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge keeps back-to-back calls from driving psel twice at once
        @(posedge ref_clk);
    endtask

    task automatic window(input int n);
        int c0, s0, w0, t0, l0;
        c0 = nc;
        s0 = ns;
        w0 = nw;
        t0 = nt;
        l0 = nl;
        cyc(n);
        c = nc - c0;
        s = ns - s0;
        w = nw - w0;
        t = nt - t0;
        l = nl - l0;
    endtask

    task automatic wait_fast(input logic v);
        int n;
        n = 0;
        while (fast_osc_on !== v && n < 20000)
        begin
            @(posedge ref_clk);
            n++;
        end
        check(32'(n < 20000), 32'h1);
        if (n >= 20000)
            close_out();
    endtask

    task automatic do_reset(input logic sx, input logic px);
        resetn <= 1'b0;
        cfg_slow_xtal <= sx;
        cfg_xtal_pins <= px;
        cyc(3);
        resetn <= 1'b1;
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial
    begin
        do_reset(0, 0);
        apb(0, CC, 0);
        check(d, 32'h0);
        check(crystal_low_power, 1'b0);
        check(fast_osc_on, 1'b1);
        cyc(500);
        apb(0, SM, 0);
        check(d & 32'hF3, 32'h03);
        apb(0, 12'h008, 0);
        check({d[30:0], e}, 32'h1);
        for (int f = 0; f < 4; f++)
        begin
            apb(1, CC, 32'(f << 4) | 32'h08);
            apb(0, CC, 0);
            check(d, 32'(f << 4) | 32'h08);
            check(crystal_low_power, 1'b1);
            cyc(200);
            window(2000);
            near(c, 2000 * fr[f] / 200);
        end
        apb(1, CC, 32'h20);
        cyc(2);
        check(crystal_low_power, 1'b0);
        // divided fast clock, sel 010 gives /64 down to 111 giving /2
        for (int k = 2; k < 8; k++)
        begin
            apb(1, SM, 32'(k << 5) | 32'h2);
            cyc(800);
            window(3200);
            near(c, 256 >> (8 - k));
        end
        apb(1, SM, 32'h03);
        cyc(1000);
        apb(1, CC, 32'hA0);
        cpu_halt <= 1'b1;
        cyc(10);
        window(2000);
        check(c, 0);
        check(32'(s > 0), 32'h1);
        // idle with the system clock released: peripherals stop too
        apb(1, CC, 32'h20);
        window(2000);
        check(c + s, 0);
        apb(1, SM, 32'h01);
        window(7000);
        check(c + s, 0);
        check(32'(w > 0 && t > 0), 32'h1);
        cpu_halt <= 1'b0;
        apb(1, SM, 32'h02);
        wait_fast(1'b0);
        apb(0, SM, 0);
        check(d[3], 1'b1);
        window(12500);
        near(c, 2);
        near(l, 2);
        apb(1, SM, 32'h03);
        wait_fast(1'b1);
        // crystal as slow source, pins given to it
        do_reset(1, 1);
        cyc(200);
        apb(0, SM, 0);
        check(d[3], 1'b0);
        check({xt1_oe, xt2_oe}, 2'b01);
        // amplifier output flips every half period of the crystal
        e = xt2_out;
        cyc(XH);
        check(xt2_out, !e);
        cyc(2500);
        apb(0, SM, 0);
        check(d[3], 1'b1);
        apb(1, SM, 32'h01);
        cpu_halt <= 1'b1;
        cyc(50);
        apb(0, SM, 0);
        check(d[3], 1'b0);
        cpu_halt <= 1'b0;
        cyc(64 * 2 * XH);
        apb(0, SM, 0);
        check(d[3], 1'b0);
        cyc(1500);
        apb(0, SM, 0);
        check(d[3], 1'b1);
        // pins as general I/O
        do_reset(0, 0);
        gpio_oe <= 2'b01;
        gpio_out <= 2'b01;
        pin2 <= 1'b1;
        cyc(8);
        check({xt1_oe, xt1_out, xt2_oe}, 3'b110);
        check(gpio_in, 2'b11);
        close_out();
    end

    initial
    begin
        #450us;
        errors++;
        close_out();
    end
endmodule
